/* File: rtl/sgc_map.vh */
// Function
// - identity word shows fixed family, part and revision codes, read only
// - start bit resets to one; zero disables the switch function except the link-loss flush, the ingress overrun drop and GC2 length bits
// - pass-all bit forwards erroneous frames too; clear drops bad frames
// - long-frame bit accepts frames up to 2000 bytes; clear drops longer
// - transmit flow control bit, reset one; clear means no pause generated
// - receive flow control bit, reset one; clear ignores received pause frames
// - length check bit drops frames whose length field below 1500 mismatches
// - aging bit, reset one, enables aging; clear stops periodic aging, but a link loss still ages out the table
// - fast age bit selects the 800 us aging period
// - aggressive back-off bit selects non-standard half-duplex back-off
// - ingress overrun sends pause when bit, start and transmit flow control bits set, otherwise drops excess frames
// - 2K bit, reset one, allows 2K frames and masks second register bits
// - pass-pause bit forwards received pause frames instead of filtering
// - link-change bit: link loss triggers one fast age cycle, then normal
// - any port losing link ages out the whole address table
`ifndef SGC_MAP_VH
`define SGC_MAP_VH
// ====================================================
// register map
`define SGC_IDX_ID 12'h000
`define SGC_IDX_GC1 12'h002
`define SGC_WORD_BYTES 12'h004
`define SGC_ADDR_ID (`SGC_IDX_ID * `SGC_WORD_BYTES)
`define SGC_ADDR_GC1 (`SGC_IDX_GC1 * `SGC_WORD_BYTES)
// ====================================================
// identity fields (values arbitrary)
`define SGC_FAMILY_CODE 8'h5a
`define SGC_PART_CODE 4'h2
`define SGC_REV_CODE 3'h3
`define SGC_START_RST 1'b1
`define SGC_B_START 0
// ====================================================
// global control one fields
`define SGC_GC1_RST 16'h3450
`define SGC_B_PASS_ALL 15
`define SGC_B_LEN2000 14
`define SGC_B_TXFC 13
`define SGC_B_RXFC 12
`define SGC_B_LENCHK 11
`define SGC_B_AGE_EN 10
`define SGC_B_FAST_AGE 9
`define SGC_B_AGGR 8
`define SGC_B_FC_INGR 5
`define SGC_B_LEN2K 4
`define SGC_B_PASS_PAUSE 3
`define SGC_B_LINK_AGE 0
// ====================================================
// frame limits
`define SGC_LEN_2000 12'h7d0
`define SGC_LEN_2K 12'h800
`define SGC_LENTYPE_MAX 16'h05dc
// ====================================================
// timing
`define SGC_CLK_HZ 36'h002625a00
`define SGC_US_PER_S 36'h0000f4240
`define SGC_FAST_AGE_US 36'h000000320
`define SGC_NORMAL_AGE_S 36'h00000012c
`define SGC_FAST_AGE_CYC (`SGC_FAST_AGE_US * `SGC_CLK_HZ / `SGC_US_PER_S)
`define SGC_NORMAL_AGE_CYC (`SGC_NORMAL_AGE_S * `SGC_CLK_HZ)
`define SGC_CNT_ONE 36'h000000001
`endif

/* File: rtl/sgc_sync.v */
`timescale 1ns/100ps
`default_nettype none
// ====================================================
// three-stage pin synchroniser with agreement filter
module sgc_sync (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire pin,
   output reg stable_r
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // s1 feeds only s2, so no logic sees a metastable value
   always @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         stable_r <= 1'b0;
      end else if (ce) begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            stable_r <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/sgc_age_timer.v */
`timescale 1ns/100ps
`default_nettype none
`include "sgc_map.vh"
// ====================================================
// aging period generator
module sgc_age_timer #(
   parameter [35:0] FAST_CYC = 36'h000007d00,
   parameter [35:0] NORMAL_CYC = 36'h2cb417800
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire age_en,
   input wire fast_en,
   input wire fast_once,
   output reg tick_r
);
   reg [35:0] cnt_r;
   wire [35:0] reload = fast_en ? FAST_CYC : NORMAL_CYC;
   always @(posedge clk) begin
      if (rst) begin
         cnt_r <= NORMAL_CYC;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= 1'b0;
         if (fast_once) begin
            // restart on the short period for a single cycle
            cnt_r <= FAST_CYC;
         end else if (!age_en) begin
            cnt_r <= reload;
         end else if (cnt_r <= `SGC_CNT_ONE) begin
            tick_r <= 1'b1;
            cnt_r <= reload;
         end else if (cnt_r > reload) begin
            // fast age switched on mid-count must not wait out a normal period
            cnt_r <= reload;
         end else begin
            cnt_r <= cnt_r - `SGC_CNT_ONE;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/sgc_regs.v */
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sgc_map.vh"
// ====================================================
// global control register bank with apb slave
module sgc_regs #(
   parameter [35:0] FAST_AGE_CYC = `SGC_FAST_AGE_CYC,
   parameter [35:0] NORMAL_AGE_CYC = `SGC_NORMAL_AGE_CYC
) (
   input wire CLOCK,
   input wire RST,
   input wire CE,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [3:0] PSTRB,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire P1_LINK,
   input wire P2_LINK,
   input wire [1:0] GC2_LEN_BITS,
   input wire FRM_VALID,
   input wire [11:0] FRM_LEN,
   input wire FRM_BAD,
   input wire FRM_PAUSE,
   input wire [15:0] FRM_LENTYPE,
   input wire [11:0] FRM_PAYLOAD,
   input wire INGRESS_OVER,
   output reg SW_ENABLE,
   output reg PASS_BAD,
   output reg LEN_2000_EN,
   output reg LEN_2K_EN,
   output reg TX_FC_EN,
   output reg RX_FC_EN,
   output reg LEN_CHECK_EN,
   output reg AGGR_BACKOFF,
   output reg PASS_PAUSE,
   output reg [1:0] GC2_LEN_EFF,
   output reg INGRESS_PAUSE,
   output reg INGRESS_DROP,
   output reg FRM_DONE,
   output reg FRM_FWD,
   output reg AGE_TICK,
   output reg AGE_FLUSH
);
   // ====================================================
   // storage
   reg start_r;
   reg [15:0] gc1_r;
   reg [1:0] link_prev_r;

   wire [1:0] link_now;
   wire age_tick;

   // ====================================================
   // apb decode
   wire sel_id = (PADDR == `SGC_ADDR_ID);
   wire sel_gc1 = (PADDR == `SGC_ADDR_GC1);
   wire hit = sel_id | sel_gc1;
   wire acc_first = PSEL & PENABLE & ~PREADY;
   wire acc_done = PSEL & PENABLE & PREADY;
   wire wr_go = acc_done & PWRITE & hit;

   wire [15:0] id_word = {
      `SGC_FAMILY_CODE,
      `SGC_PART_CODE,
      `SGC_REV_CODE,
      start_r
   };

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (sel_id) begin
         rd_mux = {16'h0000, id_word};
      end else if (sel_gc1) begin
         rd_mux = {16'h0000, gc1_r};
      end
   end

   // one wait state: pready rises in the second access cycle
   always @(posedge CLOCK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY <= acc_first;
         if (acc_first) begin
            PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
            PSLVERR <= ~hit;
         end
      end
   end

   // ====================================================
   // register writes
   // only the start bit of the identity word takes writes
   always @(posedge CLOCK) begin
      if (RST) begin
         start_r <= `SGC_START_RST;
         gc1_r <= `SGC_GC1_RST;
      end else if (CE) begin
         if (wr_go && sel_id && PSTRB[0]) begin
            start_r <= PWDATA[`SGC_B_START];
         end
         if (wr_go && sel_gc1) begin
            if (PSTRB[0]) begin
               gc1_r[7:0] <= PWDATA[7:0];
            end
            if (PSTRB[1]) begin
               gc1_r[15:8] <= PWDATA[15:8];
            end
         end
      end
   end

   // ====================================================
   // control outputs toward the switch engine
   // a stopped switch has every engine feature held off except GC2_LEN_EFF
   always @(posedge CLOCK) begin
      if (RST) begin
         SW_ENABLE <= 1'b0;
         PASS_BAD <= 1'b0;
         LEN_2000_EN <= 1'b0;
         LEN_2K_EN <= 1'b0;
         TX_FC_EN <= 1'b0;
         RX_FC_EN <= 1'b0;
         LEN_CHECK_EN <= 1'b0;
         AGGR_BACKOFF <= 1'b0;
         PASS_PAUSE <= 1'b0;
         GC2_LEN_EFF <= 2'h0;
      end else if (CE) begin
         SW_ENABLE <= start_r;
         PASS_BAD <= start_r & gc1_r[`SGC_B_PASS_ALL];
         LEN_2000_EN <= start_r & gc1_r[`SGC_B_LEN2000];
         LEN_2K_EN <= start_r & gc1_r[`SGC_B_LEN2K];
         TX_FC_EN <= start_r & gc1_r[`SGC_B_TXFC];
         RX_FC_EN <= start_r & gc1_r[`SGC_B_RXFC];
         LEN_CHECK_EN <= start_r & gc1_r[`SGC_B_LENCHK];
         AGGR_BACKOFF <= start_r & gc1_r[`SGC_B_AGGR];
         PASS_PAUSE <= start_r & gc1_r[`SGC_B_PASS_PAUSE];
         // 2K mode makes the second register's length bits void
         GC2_LEN_EFF <= gc1_r[`SGC_B_LEN2K] ? 2'h0 : GC2_LEN_BITS;
      end
   end

   // ====================================================
   // per-frame admission decision
   wire [11:0] len_limit = gc1_r[`SGC_B_LEN2K] ? `SGC_LEN_2K : `SGC_LEN_2000;
   wire too_long = (FRM_LEN > len_limit);
   wire bad_drop = FRM_BAD & ~gc1_r[`SGC_B_PASS_ALL];
   wire len_drop = gc1_r[`SGC_B_LENCHK] &
                   (FRM_LENTYPE < `SGC_LENTYPE_MAX) &
                   (FRM_LENTYPE != {4'h0, FRM_PAYLOAD});
   wire pause_drop = FRM_PAUSE & ~gc1_r[`SGC_B_PASS_PAUSE];
   wire frm_drop = ~start_r | bad_drop | too_long | len_drop | pause_drop;

   always @(posedge CLOCK) begin
      if (RST) begin
         FRM_DONE <= 1'b0;
         FRM_FWD <= 1'b0;
      end else if (CE) begin
         FRM_DONE <= FRM_VALID;
         FRM_FWD <= FRM_VALID & ~frm_drop;
      end
   end

   // ====================================================
   // ingress rate overrun response
   // pause needs the transmit flow control bit as well
   wire fc_ok = gc1_r[`SGC_B_FC_INGR] & gc1_r[`SGC_B_TXFC];
   always @(posedge CLOCK) begin
      if (RST) begin
         INGRESS_PAUSE <= 1'b0;
         INGRESS_DROP <= 1'b0;
      end else if (CE) begin
         INGRESS_PAUSE <= INGRESS_OVER & start_r & fc_ok;
         INGRESS_DROP <= INGRESS_OVER & ~(start_r & fc_ok);
      end
   end

   // ====================================================
   // link watch and aging
   sgc_sync u_sync_p1 (
      .clk(CLOCK),
      .rst(RST),
      .ce(CE),
      .pin(P1_LINK),
      .stable_r(link_now[0])
   );

   sgc_sync u_sync_p2 (
      .clk(CLOCK),
      .rst(RST),
      .ce(CE),
      .pin(P2_LINK),
      .stable_r(link_now[1])
   );

   wire link_lost = |(link_prev_r & ~link_now);
   wire fast_once = link_lost & gc1_r[`SGC_B_LINK_AGE];
   wire age_en = start_r & gc1_r[`SGC_B_AGE_EN];

   sgc_age_timer #(
      .FAST_CYC(FAST_AGE_CYC),
      .NORMAL_CYC(NORMAL_AGE_CYC)
   ) u_age (
      .clk(CLOCK),
      .rst(RST),
      .ce(CE),
      .age_en(age_en),
      .fast_en(gc1_r[`SGC_B_FAST_AGE]),
      .fast_once(fast_once),
      .tick_r(age_tick)
   );

   // link starts low after reset, so no false loss at power-up
   always @(posedge CLOCK) begin
      if (RST) begin
         link_prev_r <= 2'h0;
         AGE_TICK <= 1'b0;
         AGE_FLUSH <= 1'b0;
      end else if (CE) begin
         link_prev_r <= link_now;
         AGE_TICK <= age_tick;
         AGE_FLUSH <= link_lost;
      end
   end
endmodule
`default_nettype wire

/* File: tb/sgc_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================================================
// port checks
module sgc_chk (
   input wire CLOCK,
   input wire RST,
   input wire CE,
   input wire PREADY,
   input wire PSLVERR,
   input wire [31:0] PRDATA,
   input wire FRM_VALID,
   input wire FRM_BAD,
   input wire FRM_DONE,
   input wire FRM_FWD,
   input wire PASS_BAD,
   input wire SW_ENABLE,
   input wire LEN_2K_EN,
   input wire [1:0] GC2_LEN_EFF,
   input wire INGRESS_OVER,
   input wire INGRESS_PAUSE,
   input wire INGRESS_DROP,
   input wire P1_LINK,
   input wire AGE_FLUSH
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   upper_zero_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0)
      else $error("upper read half not zero");
   // enable outputs are registered at the decision edge, so look one cycle on
   stop_drop_a: assert property (FRM_VALID && CE |=> FRM_DONE && (SW_ENABLE || !FRM_FWD))
      else $error("frame passed while stopped");
   bad_drop_a: assert property (FRM_VALID && CE && FRM_BAD |=> PASS_BAD || !FRM_FWD)
      else $error("bad frame passed");
   frame_done_a: assert property (FRM_VALID && CE |=> FRM_DONE)
      else $error("frame not answered");
   ingress_one_a: assert property (INGRESS_OVER && CE |=> INGRESS_PAUSE != INGRESS_DROP)
      else $error("ingress overrun not pause or drop");
   ingress_cause_a: assert property (INGRESS_PAUSE || INGRESS_DROP |-> $past(INGRESS_OVER))
      else $error("ingress action without overrun");
   gc2_mask_a: assert property (LEN_2K_EN |-> GC2_LEN_EFF == 2'h0)
      else $error("second register bits not masked");
   link_flush_a: assert property ($fell(P1_LINK) |-> ##[2:8] AGE_FLUSH)
      else $error("no flush after link loss");
   flush_pulse_a: assert property (AGE_FLUSH |=> !AGE_FLUSH)
      else $error("flush longer than one cycle");
   frame_fwd_c: cover property (FRM_DONE && FRM_FWD);
   ingress_pause_c: cover property (INGRESS_PAUSE);
   slverr_c: cover property (PSLVERR);
endmodule
bind sgc_regs sgc_chk sgc_chk_inst (.CLOCK, .RST, .CE, .PREADY, .PSLVERR, .PRDATA, .FRM_VALID,
   .FRM_BAD, .FRM_DONE, .FRM_FWD, .PASS_BAD, .SW_ENABLE, .LEN_2K_EN, .GC2_LEN_EFF,
   .INGRESS_OVER, .INGRESS_PAUSE, .INGRESS_DROP, .P1_LINK, .AGE_FLUSH);
`default_nettype wire

/* File: tb/sgc_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sgc_map.vh"
// ====================================================
// bench
module sgc_regs_tb;
   logic CLOCK = 1'h0, RST = 1'h1, CE = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic FRM_VALID = 1'h0, FRM_BAD = 1'h0, FRM_PAUSE = 1'h0, INGRESS_OVER = 1'h0;
   logic P1_LINK = 1'h1, P2_LINK = 1'h1, st = 1'h1;
   logic [11:0] PADDR = 12'h0, FRM_LEN = 12'h0, FRM_PAYLOAD = 12'h0;
   logic [31:0] PWDATA = 32'h0;
   logic [3:0] PSTRB = 4'hf, sb = 4'hf;
   logic [1:0] GC2_LEN_BITS = 2'h0;
   logic [15:0] FRM_LENTYPE = 16'h0, gc = `SGC_GC1_RST;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, SW_ENABLE, PASS_BAD, LEN_2000_EN, LEN_2K_EN, TX_FC_EN, RX_FC_EN;
   wire LEN_CHECK_EN, AGGR_BACKOFF, PASS_PAUSE, INGRESS_PAUSE, INGRESS_DROP;
   wire FRM_DONE, FRM_FWD, AGE_TICK, AGE_FLUSH;
   wire [1:0] GC2_LEN_EFF;
   logic [16:0] q[$];
   int errors = 0, n_compared = 0, k, nt, nf;
   localparam [15:0] ID = {`SGC_FAMILY_CODE, `SGC_PART_CODE, `SGC_REV_CODE, 1'h0};
   always #12.5 CLOCK = ~CLOCK;
   // short aging counts keep the run brief
   sgc_regs #(.FAST_AGE_CYC(36'h14), .NORMAL_AGE_CYC(36'h64)) sgc_regs_inst (.CLOCK, .RST, .CE,
      .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .P1_LINK,
      .P2_LINK, .GC2_LEN_BITS, .FRM_VALID, .FRM_LEN, .FRM_BAD, .FRM_PAUSE, .FRM_LENTYPE,
      .FRM_PAYLOAD, .INGRESS_OVER, .SW_ENABLE, .PASS_BAD, .LEN_2000_EN, .LEN_2K_EN, .TX_FC_EN,
      .RX_FC_EN, .LEN_CHECK_EN, .AGGR_BACKOFF, .PASS_PAUSE, .GC2_LEN_EFF, .INGRESS_PAUSE,
      .INGRESS_DROP, .FRM_DONE, .FRM_FWD, .AGE_TICK, .AGE_FLUSH);
   // ====================================================
   // tasks
   task check(input [16:0] got, input [16:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task apb(input w, input [11:0] a, input [15:0] d);
      PSEL <= 1'h1;
      PSTRB <= sb;
      PWRITE <= w;
      PADDR <= a;
      // upper lanes carry a copy so ignored lanes get exercised
      PWDATA <= {d, d};
      @(posedge CLOCK);
      PENABLE <= 1'h1;
      // only the watchdog ends a hung wait
      do begin
         @(posedge CLOCK);
      end while (PREADY !== 1'h1);
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge CLOCK);
   endtask
   task rd(input [11:0] a, input [16:0] e);
      q.push_back(e);
      apb(1'h0, a, 16'h0);
   endtask
   task wr(input [11:0] a, input [15:0] d);
      if (a == `SGC_ADDR_GC1) gc = {sb[1] ? d[15:8] : gc[15:8], sb[0] ? d[7:0] : gc[7:0]};
      if (a == `SGC_ADDR_ID && sb[0]) st = d[0];
      apb(1'h1, a, d);
   endtask
   task frame;
      logic b, p, f;
      logic [11:0] l, pl;
      logic [15:0] lt;
      b = 1'($urandom);
      p = 1'($urandom);
      // ranges straddle both length limits and the length field bound
      l = 12'h7cc + 12'($urandom % 64);
      lt = 16'($urandom % 1600);
      pl = ($urandom % 2) ? lt[11:0] : 12'($urandom);
      f = st && (!b || gc[15]) && l <= (gc[4] ? 12'h800 : 12'h7d0) && (!p || gc[3])
         && !(gc[11] && lt < 16'h5dc && lt != {4'h0, pl});
      q.push_back({16'h0, f});
      FRM_VALID <= 1'h1;
      FRM_BAD <= b;
      FRM_PAUSE <= p;
      FRM_LEN <= l;
      FRM_LENTYPE <= lt;
      FRM_PAYLOAD <= pl;
      GC2_LEN_BITS <= 2'($urandom);
      @(posedge CLOCK);
      FRM_VALID <= 1'h0;
      INGRESS_OVER <= 1'h1;
      q.push_back({16'h0, st & gc[5] & gc[13]});
      @(posedge CLOCK);
      INGRESS_OVER <= 1'h0;
      @(posedge CLOCK);
      check({6'h0, SW_ENABLE, PASS_BAD, LEN_2000_EN, LEN_2K_EN, TX_FC_EN, RX_FC_EN, LEN_CHECK_EN,
         AGGR_BACKOFF, PASS_PAUSE, GC2_LEN_EFF}, {6'h0, st, {8{st}} & {gc[15], gc[14], gc[4],
         gc[13], gc[12], gc[11], gc[8], gc[3]}, gc[4] ? 2'h0 : GC2_LEN_BITS});
   endtask
   task watch(input int c);
      nt = 0;
      nf = 0;
      repeat (c) begin
         @(posedge CLOCK);
         nt += AGE_TICK;
         nf += AGE_FLUSH;
      end
   endtask
   // ====================================================
   // result monitor
   always @(posedge CLOCK) begin
      if ((PREADY && !PWRITE) || FRM_DONE || INGRESS_PAUSE || INGRESS_DROP) begin
         if (q.size() == 0) check(17'h1, 17'h0);
         else if (FRM_DONE) check({16'h0, FRM_FWD}, q.pop_front());
         else if (!PREADY) check({16'h0, INGRESS_PAUSE}, q.pop_front());
         else check({PSLVERR, PRDATA[15:0]}, q.pop_front());
      end
   end
   initial begin
      #200000;
      errors++;
      print_verdict;
   end
   // ====================================================
   // main sequence
   initial begin
      k = $urandom(32'he79a655d);
      repeat (10) @(posedge CLOCK);
      RST <= 1'h0;
      @(posedge CLOCK);
      rd(`SGC_ADDR_ID, {1'h0, ID | 16'h1});
      rd(`SGC_ADDR_GC1, {1'h0, `SGC_GC1_RST});
      wr(12'h00c, 16'h0);
      rd(12'h004, 17'h10000);
      rd(`SGC_ADDR_GC1, {1'h0, `SGC_GC1_RST});
      wr(`SGC_ADDR_ID, 16'hfffe);
      rd(`SGC_ADDR_ID, {1'h0, ID});
      frame;
      wr(`SGC_ADDR_ID, 16'h0001);
      for (k = 0; k < 14; k++) begin
         wr(`SGC_ADDR_GC1, k < 2 ? {16{k[0]}} : 16'($urandom));
         rd(`SGC_ADDR_GC1, {1'h0, gc});
         repeat (4) frame;
      end
      // clock enable low stalls the slave in the middle of a read
      CE <= 1'h0;
      fork
         rd(`SGC_ADDR_GC1, {1'h0, gc});
         begin
            repeat (6) @(posedge CLOCK);
            CE <= 1'h1;
         end
      join
      // mid-run reset brings every default back
      RST <= 1'h1;
      repeat (3) @(posedge CLOCK);
      RST <= 1'h0;
      gc = `SGC_GC1_RST;
      st = 1'h1;
      @(posedge CLOCK);
      rd(`SGC_ADDR_ID, {1'h0, ID | 16'h1});
      rd(`SGC_ADDR_GC1, {1'h0, gc});
      wr(`SGC_ADDR_GC1, gc | 16'h0028);
      // single lanes: upper byte only, and no start-bit lane
      sb = 4'h2;
      wr(`SGC_ADDR_GC1, 16'hffff);
      wr(`SGC_ADDR_ID, 16'h0000);
      sb = 4'hf;
      rd(`SGC_ADDR_GC1, {1'h0, gc});
      rd(`SGC_ADDR_ID, {1'h0, ID | 16'h1});
      wr(`SGC_ADDR_GC1, 16'h0001);
      wr(`SGC_ADDR_GC1, 16'h0401);
      P1_LINK <= 1'h0;
      watch(40);
      check({15'h0, nf == 1, nt == 1}, 17'h3);
      watch(60);
      check({16'h0, nt == 0}, 17'h1);
      P1_LINK <= 1'h1;
      wr(`SGC_ADDR_GC1, 16'h0000);
      P2_LINK <= 1'h0;
      watch(250);
      check({15'h0, nf == 1, nt == 0}, 17'h3);
      wr(`SGC_ADDR_GC1, 16'h0600);
      watch(60);
      check({16'h0, nt > 1}, 17'h1);
      repeat (5) @(posedge CLOCK);
      check({16'h0, q.size() == 0}, 17'h1);
      print_verdict;
   end
endmodule
`default_nettype wire
